//--- hw/mcs_map.vh
// register offsets, microword field positions and timing counts of the control store
`ifndef MCS_MAP_VH
`define MCS_MAP_VH
// register byte offsets
`define MCS_CTRL_OFS     8'h00
`define MCS_LDADDR_OFS   8'h04
`define MCS_LDLO_OFS     8'h08
`define MCS_LDHI_OFS     8'h0c
`define MCS_STATUS_OFS   8'h10
`define MCS_BUFLO_OFS    8'h14
`define MCS_BUFHI_OFS    8'h18
// control register bits
`define MCS_CTRL_RUN     0
`define MCS_CTRL_EXT     1
// store geometry
`define MCS_DEPTH        256
`define MCS_WIDTH        56
// microword field positions (bit 08 is not stored)
`define MCS_F_CLKHI      56
`define MCS_F_CLKLO      55
`define MCS_F_STOP       54
`define MCS_F_IRLD       53
`define MCS_F_WRH        52
`define MCS_F_WRL        51
`define MCS_F_BLD        50
`define MCS_F_DLD        49
`define MCS_F_BALD       48
`define MCS_F_XHI        47
`define MCS_F_XLO        46
`define MCS_F_XGO        45
`define MCS_F_BAM        22
`define MCS_F_SRS        16
`define MCS_F_SRD        15
`define MCS_F_REG_ADDR_FROM_BUS_ADDR       14
`define MCS_F_SRI        13
`define MCS_F_EXT        8
// processor cycle lengths in ns and in hclk cycles (50 MHz, rounded up)
`define MCS_CLK_MHZ      50
`define MCS_CYC_S_NS     140
`define MCS_CYC_M_NS     200
`define MCS_CYC_L_NS     300
`define MCS_CYC_S_CLKS   ((`MCS_CYC_S_NS * `MCS_CLK_MHZ + 999) / 1000)
`define MCS_CYC_M_CLKS   ((`MCS_CYC_M_NS * `MCS_CLK_MHZ + 999) / 1000)
`define MCS_CYC_L_CLKS   ((`MCS_CYC_L_NS * `MCS_CLK_MHZ + 999) / 1000)
`endif

//--- hw/mcs_control_store.v
// microword control store, sequencer and field decode with an ahb-lite slave
`include "mcs_map.vh"
`timescale 1ns/1ps
`default_nettype none

module mcs_control_store (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [31:0] branch_cond_in,
  input  wire        next_micro_addr_ext_in,
  input  wire [15:0] instr_reg_in,
  input  wire [3:0]  bus_addr_reg_in,
  output reg         proc_cycle_tick,
  output reg  [1:0]  cycle_length_sel,
  output reg         processor_clock_stop,
  output reg         instr_reg_load,
  output reg         gpr_write_high_byte,
  output reg         gpr_write_low_byte,
  output reg         operand_b_load,
  output reg         result_reg_load,
  output reg         bus_addr_reg_load,
  output reg  [1:0]  bus_xfer_type,
  output reg         bus_xfer_begin,
  output reg  [3:0]  datapath_alter_sel,
  output reg  [2:0]  status_word_ctl,
  output reg         alu_mode_sel,
  output reg  [3:0]  alu_function_sel,
  output reg  [3:0]  b_constant_sel,
  output reg  [1:0]  b_mux_high_sel,
  output reg  [1:0]  b_mux_low_sel,
  output reg  [1:0]  d_mux_sel,
  output reg         bus_addr_mux_sel,
  output reg  [3:0]  gpr_addr,
  output reg  [8:0]  microprogram_pointer
);

  ////////////////////////////////////////////////////////////////////////////
  // storage and state

  reg [55:0] store [0:`MCS_DEPTH-1];
  reg [56:0] mword_reg;                // buffer, bit 08 included
  reg [8:0]  ptr_reg;
  reg [3:0]  len_cnt_reg;
  reg        run_reg;
  reg        ext_fit_reg;
  reg        stopped_reg;
  reg [7:0]  ld_addr_reg;
  reg [23:0] ld_hi_reg;
  reg        dp_wr_reg;
  reg [7:0]  dp_addr_reg;

  // expand a stored 56-bit word to 57 positions, bit 08 from the option
  function [56:0] expand_word;
    input [55:0] w;
    input        ext_bit;
    begin
      expand_word = {w[55:8], ext_bit, w[7:0]};
    end
  endfunction

  // cycle lengths in hclk counts; the full-width constants are cut to the
  // counter width on purpose, since every length fits in four bits
  localparam [31:0] LEN_SHORT_W = `MCS_CYC_S_CLKS;
  localparam [31:0] LEN_MED_W   = `MCS_CYC_M_CLKS;
  localparam [31:0] LEN_LONG_W  = `MCS_CYC_L_CLKS;
  localparam [3:0]  LEN_SHORT   = LEN_SHORT_W[3:0];
  localparam [3:0]  LEN_MED     = LEN_MED_W[3:0];
  localparam [3:0]  LEN_LONG    = LEN_LONG_W[3:0];

  // hclk cycles per processor cycle for a length code; the two upper
  // codes share the long length, so only three lengths exist
  function [3:0] cycle_clks;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   cycle_clks = LEN_SHORT;
        2'b01:   cycle_clks = LEN_MED;
        default: cycle_clks = LEN_LONG;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // processor cycle timing

  wire [3:0] cur_len = cycle_clks(mword_reg[`MCS_F_CLKHI:`MCS_F_CLKLO]);
  wire       active  = run_reg & ~stopped_reg;
  wire       tick    = active & (len_cnt_reg >= cur_len - 4'h1);

  // fetch path: word at the pointer, its next field modified by the test.
  // the test belongs to the buffered word, so it steers the word after next:
  // the next word is already in the pointer and cannot be changed any more
  // limitation: pointer bit 8 never indexes the store, it is only exported
  wire [56:0] fetched  = expand_word(store[ptr_reg[7:0]],
                                     ext_fit_reg & next_micro_addr_ext_in);
  wire [4:0]  ubf      = mword_reg[21:17];
  wire        taken    = (ubf != 5'h00) & branch_cond_in[ubf];
  wire [8:0]  next_ptr = {fetched[`MCS_F_EXT], fetched[7:1],
                          fetched[0] | taken};

  // cycle length counter; restarts at every processor cycle edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      len_cnt_reg <= 4'h0;
    end else if (!active || tick) begin
      len_cnt_reg <= 4'h0;
    end else begin
      len_cnt_reg <= len_cnt_reg + 4'h1;
    end
  end

  // one word into the buffer and one address into the pointer per cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mword_reg <= 57'h0;
      ptr_reg   <= 9'h000;
    end else if (tick) begin
      mword_reg <= fetched;
      ptr_reg   <= next_ptr;
    end
  end

  // clock stop: the cycle whose word has bit 54 ends, then nothing ticks
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stopped_reg <= 1'b0;
    end else if (tick && mword_reg[`MCS_F_STOP]) begin
      stopped_reg <= 1'b1;
    end else if (dp_wr_reg && dp_addr_reg == `MCS_CTRL_OFS && hwdata[`MCS_CTRL_RUN]) begin
      stopped_reg <= 1'b0;      // set above wins over this restart
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode to flopped outputs

  // register address source; literal only when its enable is set
  function [3:0] reg_addr_sel;
    input [56:0] w;
    input [15:0] ir;
    input [3:0]  ba;
    begin
      if (w[`MCS_F_SRS])
        reg_addr_sel = {1'b0, ir[8:6]};
      else if (w[`MCS_F_SRD])
        reg_addr_sel = {1'b0, ir[2:0]};
      else if (w[`MCS_F_REG_ADDR_FROM_BUS_ADDR])
        reg_addr_sel = ba;
      else if (w[`MCS_F_SRI])
        reg_addr_sel = w[12:9];
      else
        reg_addr_sel = 4'h0;
    end
  endfunction

  // named slices of the buffered word, one per control field
  wire [1:0] f_len      = mword_reg[`MCS_F_CLKHI:`MCS_F_CLKLO];
  wire       f_irld     = mword_reg[`MCS_F_IRLD];
  wire       f_wrh      = mword_reg[`MCS_F_WRH];
  wire       f_wrl      = mword_reg[`MCS_F_WRL];
  wire       f_bld      = mword_reg[`MCS_F_BLD];
  wire       f_dld      = mword_reg[`MCS_F_DLD];
  wire       f_bald     = mword_reg[`MCS_F_BALD];
  wire [1:0] f_xtype    = mword_reg[`MCS_F_XHI:`MCS_F_XLO];
  wire       f_xgo      = mword_reg[`MCS_F_XGO];
  wire [3:0] f_alter    = mword_reg[44:41];
  wire [2:0] f_status   = mword_reg[40:38];
  wire       f_alu_mode = mword_reg[37];
  wire [3:0] f_alu_fn   = mword_reg[36:33];
  wire [3:0] f_bconst   = mword_reg[32:29];
  wire [1:0] f_bmux_hi  = mword_reg[28:27];
  wire [1:0] f_bmux_lo  = mword_reg[26:25];
  wire [1:0] f_dmux     = mword_reg[24:23];
  wire       f_bamux    = mword_reg[`MCS_F_BAM];

  // load strobes: qualified with the cycle edge, so each one belongs to the
  // word whose cycle is ending and the datapath loads at that edge only
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      proc_cycle_tick     <= 1'b0;
      instr_reg_load      <= 1'b0;
      gpr_write_high_byte <= 1'b0;
      gpr_write_low_byte  <= 1'b0;
      operand_b_load      <= 1'b0;
      result_reg_load     <= 1'b0;
      bus_addr_reg_load   <= 1'b0;
      bus_xfer_begin      <= 1'b0;
    end else begin
      proc_cycle_tick     <= tick;
      instr_reg_load      <= tick & f_irld;
      gpr_write_high_byte <= tick & f_wrh;
      gpr_write_low_byte  <= tick & f_wrl;
      operand_b_load      <= tick & f_bld;
      result_reg_load     <= tick & f_dld;
      bus_addr_reg_load   <= tick & f_bald;
      bus_xfer_begin      <= tick & f_xgo;
    end
  end

  // level fields copy the buffer one hclk late; they stand for the whole
  // processor cycle, which is far longer than that one hclk of lag
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cycle_length_sel     <= 2'b00;
      processor_clock_stop <= 1'b0;
      bus_xfer_type        <= 2'b00;
      datapath_alter_sel   <= 4'h0;
      status_word_ctl      <= 3'h0;
      alu_mode_sel         <= 1'b0;
      alu_function_sel     <= 4'h0;
      b_constant_sel       <= 4'h0;
      b_mux_high_sel       <= 2'b00;
      b_mux_low_sel        <= 2'b00;
      d_mux_sel            <= 2'b00;
      bus_addr_mux_sel     <= 1'b0;
    end else begin
      cycle_length_sel     <= f_len;
      processor_clock_stop <= stopped_reg;
      bus_xfer_type        <= f_xtype;
      datapath_alter_sel   <= f_alter;
      status_word_ctl      <= f_status;
      alu_mode_sel         <= f_alu_mode;
      alu_function_sel     <= f_alu_fn;
      b_constant_sel       <= f_bconst;
      b_mux_high_sel       <= f_bmux_hi;
      b_mux_low_sel        <= f_bmux_lo;
      d_mux_sel            <= f_dmux;
      bus_addr_mux_sel     <= f_bamux;
    end
  end

  // register address and pointer copy; the address follows the instruction
  // and bus address inputs as well, so it settles one hclk after they load
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpr_addr             <= 4'h0;
      microprogram_pointer <= 9'h000;
    end else begin
      gpr_addr             <= reg_addr_sel(mword_reg, instr_reg_in, bus_addr_reg_in);
      microprogram_pointer <= ptr_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always okay

  wire ap_valid = hsel & hready & htrans[1];

  // capture the address phase of a write for its data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg   <= 1'b0;
      dp_addr_reg <= 8'h00;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      dp_wr_reg   <= ap_valid & hwrite;
      dp_addr_reg <= haddr[7:0];
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
  end

  // software registers; the store only takes words while halted, so the
  // sequencer never sees a word change under it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg     <= 1'b0;
      ext_fit_reg <= 1'b0;
      ld_addr_reg <= 8'h00;
      ld_hi_reg   <= 24'h0;
    end else if (dp_wr_reg) begin
      case (dp_addr_reg)
        `MCS_CTRL_OFS: begin
          run_reg     <= hwdata[`MCS_CTRL_RUN];
          ext_fit_reg <= hwdata[`MCS_CTRL_EXT];
        end
        `MCS_LDADDR_OFS: begin
          ld_addr_reg <= hwdata[7:0];
        end
        `MCS_LDHI_OFS: begin
          ld_hi_reg <= hwdata[23:0];
        end
        `MCS_LDLO_OFS: begin
          if (!run_reg) begin
            ld_addr_reg <= ld_addr_reg + 8'h01;
          end
        end
        default: begin
          run_reg <= run_reg;
        end
      endcase
    end
  end

  // store array write, separate so it infers as memory
  always @(posedge hclk) begin
    if (dp_wr_reg && dp_addr_reg == `MCS_LDLO_OFS && !run_reg) begin
      store[ld_addr_reg] <= {ld_hi_reg, hwdata};
    end
  end

  // read data prepared in the address phase, flopped for the data phase
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h0;
    case (haddr[7:0])
      `MCS_CTRL_OFS:   rd_next = {30'h0, ext_fit_reg, run_reg};
      `MCS_LDADDR_OFS: rd_next = {24'h0, ld_addr_reg};
      `MCS_LDHI_OFS:   rd_next = {8'h00, ld_hi_reg};
      `MCS_STATUS_OFS: rd_next = {21'h0, stopped_reg, active, ptr_reg};
      `MCS_BUFLO_OFS:  rd_next = mword_reg[31:0];
      `MCS_BUFHI_OFS:  rd_next = {7'h00, mword_reg[56:32]};
      default:         rd_next = 32'h0;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (ap_valid && !hwrite) begin
      hrdata <= rd_next;
    end
  end

endmodule // mcs_control_store

`default_nettype wire

//--- dv/mcs_chk.sv
// assertion checker for the control store ports
`timescale 1ns/1ps
`default_nettype none
module mcs_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       proc_cycle_tick,
  input wire logic [1:0] cycle_length_sel,
  input wire logic       processor_clock_stop,
  input wire logic       instr_reg_load,
  input wire logic       result_reg_load,
  input wire logic       bus_xfer_begin,
  input wire logic [3:0] alu_function_sel,
  input wire logic [3:0] b_constant_sel,
  input wire logic [8:0] microprogram_pointer
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // a stop may replace the next tick, so the far end accepts either
  AST_LEN_SHORT: assert property (proc_cycle_tick ##1 cycle_length_sel == 2'h0 |=>
    !proc_cycle_tick [*5] ##1 (proc_cycle_tick || processor_clock_stop))
    else $error("short cycle length wrong");
  AST_LEN_MED: assert property (proc_cycle_tick ##1 cycle_length_sel == 2'h1 |=>
    !proc_cycle_tick [*8] ##1 (proc_cycle_tick || processor_clock_stop))
    else $error("medium cycle length wrong");
  AST_LEN_LONG: assert property (proc_cycle_tick ##1 cycle_length_sel[1] |=>
    !proc_cycle_tick [*8] ##1 !proc_cycle_tick [*5] ##1
    (proc_cycle_tick || processor_clock_stop))
    else $error("long cycle length wrong");
  AST_STROBE_IN_TICK: assert property ((instr_reg_load || result_reg_load || bus_xfer_begin)
    |-> proc_cycle_tick) else $error("strobe outside a cycle edge");
  AST_STROBE_ONE: assert property ($rose(bus_xfer_begin) |=> $fell(bus_xfer_begin))
    else $error("transfer start longer than one clock");
  AST_FIELDS_HOLD: assert property (!proc_cycle_tick && !$past(proc_cycle_tick) |->
    $stable({alu_function_sel, b_constant_sel, cycle_length_sel}))
    else $error("field changed inside a cycle");
  AST_PTR_HOLD: assert property (!proc_cycle_tick && !$past(proc_cycle_tick) |->
    $stable(microprogram_pointer))
    else $error("pointer changed inside a cycle");
  AST_STOP_HALTS: assert property (processor_clock_stop && $past(processor_clock_stop)
    |-> !proc_cycle_tick) else $error("tick while stopped");
endmodule // mcs_chk
bind mcs_control_store mcs_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .proc_cycle_tick(proc_cycle_tick), .cycle_length_sel(cycle_length_sel),
  .processor_clock_stop(processor_clock_stop), .instr_reg_load(instr_reg_load),
  .result_reg_load(result_reg_load), .bus_xfer_begin(bus_xfer_begin),
  .alu_function_sel(alu_function_sel), .b_constant_sel(b_constant_sel),
  .microprogram_pointer(microprogram_pointer));
`default_nettype wire

//--- dv/mcs_dp_model.sv
// datapath stand-in holding the instruction and bus address registers
`timescale 1ns/1ps
`default_nettype none
module mcs_dp_model (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        instr_reg_load,
  input wire logic        bus_addr_reg_load,
  input wire logic [15:0] bus_data,
  input wire logic [3:0]  alu_value,
  output logic     [15:0] instr_reg,
  output logic     [3:0]  bus_addr_reg
);
  // loads only on the strobes, so a missed strobe shows up in the register address
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr_reg    <= 16'h0000;
      bus_addr_reg <= 4'h0;
    end else begin
      if (instr_reg_load) instr_reg <= bus_data;
      if (bus_addr_reg_load) bus_addr_reg <= alu_value;
    end
  end
endmodule // mcs_dp_model
`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the microword control store
`include "mcs_map.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic hclk, hresetn = 0, hsel = 0, hwrite = 0, ext = 0;
  logic [31:0] haddr = 0, hwdata = 0, cond = 0;
  logic [1:0]  htrans = 0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, tick, stp, irl, wh, wl, bl, dl, bal, bxb, alm, bam;
  wire [1:0] cls, bxt, bmh, bml, dms;
  wire [2:0] swc;
  wire [3:0] dal, alf, bcs, gpa, ba;
  wire [8:0] ptr;
  wire [15:0] ir;
  logic [6:0] strb;
  int num_errors = 0;
  int check_count = 0;
  mcs_control_store DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .branch_cond_in(cond),
    .next_micro_addr_ext_in(ext), .instr_reg_in(ir), .bus_addr_reg_in(ba),
    .proc_cycle_tick(tick), .cycle_length_sel(cls), .processor_clock_stop(stp),
    .instr_reg_load(irl), .gpr_write_high_byte(wh), .gpr_write_low_byte(wl),
    .operand_b_load(bl), .result_reg_load(dl), .bus_addr_reg_load(bal),
    .bus_xfer_type(bxt), .bus_xfer_begin(bxb), .datapath_alter_sel(dal),
    .status_word_ctl(swc), .alu_mode_sel(alm), .alu_function_sel(alf),
    .b_constant_sel(bcs), .b_mux_high_sel(bmh), .b_mux_low_sel(bml), .d_mux_sel(dms),
    .bus_addr_mux_sel(bam), .gpr_addr(gpa), .microprogram_pointer(ptr));
  mcs_dp_model u_dp (.hclk(hclk), .hresetn(hresetn), .instr_reg_load(irl),
    .bus_addr_reg_load(bal), .bus_data(16'h0143), .alu_value(4'hc), .instr_reg(ir),
    .bus_addr_reg(ba));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [63:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic rst();
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  // one single transfer; entered just after a rising edge, the slave may stall
  task automatic xf(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // stored word drops bit 8, the extension option supplies it
  task automatic ld(input logic [7:0] a, input logic [56:0] w);
    logic [31:0] r;
    xf(1'b1, `MCS_LDADDR_OFS, {24'h0, a}, r);
    xf(1'b1, `MCS_LDHI_OFS, {8'h0, w[56:33]}, r);
    xf(1'b1, `MCS_LDLO_OFS, {w[32:9], w[7:0]}, r);
  endtask
  task automatic tk(output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (tick !== 1'b1);
    strb = {irl, wh, wl, bl, dl, bal, bxb};
    @(negedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] r;
    xf(1'b0, `MCS_STATUS_OFS, 0, r);
    chk("status", r, 0);
    chk("hresp", hresp, 0);
    xf(1'b1, 32'h1c, 32'hffffffff, r);
    xf(1'b0, 32'h1c, 0, r);
    chk("unmapped", r, 0);
    $display("test regs done");
  endtask
  // complementary words toggle every field bit but stop, branch test and next address; strobes and lengths both ways
  task automatic t_fields();
    logic [56:0] a, m, w0, w1;
    logic [31:0] r;
    int n;
    a = 57'h1aa_aaaa_aaaa_aaaa;
    m = ~57'h40_0000_003e_01ff;
    w0 = (a & m) | 57'h1;
    w1 = ~a & m;
    rst();
    ld(0, w0);
    ld(1, w1);
    xf(1'b1, `MCS_CTRL_OFS, 1, r);
    tk(n);
    chk("strobes_rst", strb, 7'h00);
    chk("fields0", {cls,bxt,dal,swc,alm,alf,bcs,bmh,bml,dms,bam}, {w0[56:55], w0[47:46], w0[44:22]});
    chk("ptr0", ptr, 9'h001);
    tk(n);
    chk("len11", n, `MCS_CYC_L_CLKS);
    chk("strobes0", strb, {w0[53:48], w0[45]});
    chk("fields1", {cls,bxt,dal,swc,alm,alf,bcs,bmh,bml,dms,bam}, {w1[56:55], w1[47:46], w1[44:22]});
    tk(n);
    chk("len00", n, `MCS_CYC_S_CLKS);
    chk("strobes1", strb, {w1[53:48], w1[45]});
    $display("test fields done");
  endtask
  task automatic t_gpr();
    logic [56:0] wt [6] = '{57'h21_0000_0000_0000, 57'h1_0000, 57'h8000, 57'h4000,
                            57'h3200, 57'h40_0000_0001_e000};
    logic [3:0] ge [6] = '{4'h0, 4'h5, 4'h3, 4'hc, 4'h9, 4'h5};
    logic [31:0] r;
    int n;
    rst();
    for (int i = 0; i < 6; i++) begin
      ld(i[7:0], wt[i] | 57'(i + 1));
    end
    ld(6, 57'h40_0000_0000_0006);
    xf(1'b1, `MCS_CTRL_OFS, 1, r);
    for (int i = 0; i < 6; i++) begin
      tk(n);
      @(negedge hclk);
      chk("gpr_addr", gpa, ge[i]);
    end
    repeat (20) @(posedge hclk);
    chk("stop", stp, 1);
    xf(1'b0, `MCS_STATUS_OFS, 0, r);
    chk("stopped", r[10], 1);
    $display("test gpr done");
  endtask
  // branch acts on the word after next; bit 8 from the fitted option
  task automatic t_branch();
    logic [31:0] r;
    int n;
    rst();
    cond <= 32'h8;
    ext <= 1'b1;
    ld(0, 57'h80_0000_0006_0002);
    ld(2, 57'he_0004);
    ld(5, 57'h40_0000_0000_0006);
    ld(6, 57'h40_0000_0000_0006);
    xf(1'b1, `MCS_CTRL_OFS, 3, r);
    tk(n);
    chk("ptr_a", ptr, 9'h102);
    tk(n);
    chk("len01", n, `MCS_CYC_M_CLKS);
    chk("ptr_b", ptr, 9'h105);
    tk(n);
    chk("ptr_c", ptr, 9'h106);
    $display("test branch done");
  endtask
  initial begin
    rst();
    t_regs();
    t_fields();
    t_gpr();
    t_branch();
    summarize();
  end
endmodule // tb
`default_nettype wire
